// ### board_pins.sv
// Board side of the general pins.
// Assumes the board drives a pin only while the block does not.
`timescale 1ns/1ps
module board_pins (
  input wire logic [15:0] pin_o,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] board_lvl,
  output logic [15:0] pin_i
);
  // Wire level from both parties
  assign pin_i = (pin_o & pin_oe) | (board_lvl & ~pin_oe);
endmodule // board_pins

// ### gpio_pkg.sv
// Constants for the multi-function pin block.
// Assumes a 32-bit AXI4-Lite master and one 250 MHz system clock.
// Function
// - Sixteen general pins, zero to fifteen, each with its own configuration.
// - Any pin may take any function on any monitor or PLL.
// - Driving pin functions act only once the reset sequence has finished; input sampling does not wait.
// - Input mode samples the pin into a readable register; it is default.
// - Output mode drives the pin from a software-written register bit.
// - Per-pin alarm setup; identical setups give identical outputs.
// - Loss-of-signal mode is high while selected monitor alarms; invertible.
// - Loss-of-signal output follows the live alarm, never latched.
// - Registers select the monitor and PLL channel feeding each pin.
// - Live loss-of-lock mode is high while the selected PLL is unlocked.
// - Sticky loss-of-lock asserts when the PLL gains or loses lock.
// - An option inverts the sticky loss-of-lock indication.
// - Sticky indications hold until software writes the clear register.
// - Alert mode ORs all enabled sticky bits, invertible, clears when all clear.
// - Each sticky bit sets on any change of its alarm condition.
package gpio_pkg;
  localparam int unsigned num_pins = 16;
  localparam int unsigned num_mon = 8;
  localparam int unsigned num_pll = 8;
  localparam int unsigned sel_w = 3;
  localparam int unsigned addr_w = 8;

  // Byte addresses
  localparam logic [addr_w-1:0] adr_pin_in = 8'h00;
  localparam logic [addr_w-1:0] adr_pin_out = 8'h04;
  localparam logic [addr_w-1:0] adr_lol_sticky = 8'h08;
  localparam logic [addr_w-1:0] adr_lol_clear = 8'h0c;
  localparam logic [addr_w-1:0] adr_alert_en = 8'h10;
  localparam logic [addr_w-1:0] adr_irq_status = 8'h14;
  localparam logic [addr_w-1:0] adr_irq_clear = 8'h18;
  localparam logic [addr_w-1:0] adr_irq_enable = 8'h1c;
  localparam logic [addr_w-1:0] adr_ready = 8'h20;
  localparam logic [addr_w-1:0] adr_pin_cfg0 = 8'h40;

  // Pin configuration word fields
  localparam int unsigned cfg_mode_lsb = 0;
  localparam int unsigned cfg_sel_lsb = 4;
  localparam int unsigned cfg_inv_bit = 8;
  localparam int unsigned cfg_oe_bit = 9;
  localparam logic [31:0] cfg_reset = 32'h0000_0000;

  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  typedef enum logic [2:0] {
    mode_input,
    mode_output,
    mode_los,
    mode_lol_live,
    mode_lol_sticky,
    mode_alert
  } pin_mode_e;
endpackage

// ### gpio_top.sv
// Multi-function pin block with an AXI4-Lite register slave.
// Assumes reset sequence done flag and alarm sources on sys_clk.
`timescale 1ns/1ps
module gpio_top
  import gpio_pkg::*;
#(
  parameter int unsigned pins = gpio_pkg::num_pins
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic reset_done,
  input wire logic [gpio_pkg::num_mon-1:0] los_alarm,
  input wire logic [gpio_pkg::num_pll-1:0] pll_locked,
  input wire logic [gpio_pkg::num_pins-1:0] pin_i,
  output logic [gpio_pkg::num_pins-1:0] pin_o,
  output logic [gpio_pkg::num_pins-1:0] pin_oe,
  output logic irq,
  input wire logic [gpio_pkg::addr_w-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gpio_pkg::addr_w-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import gpio_pkg::*;

  // Register state
  logic [31:0] cfg [pins];
  logic [31:0] next_cfg [pins];
  logic [pins-1:0] out_val, next_out_val;
  logic [num_pll-1:0] alert_en, next_alert_en;
  logic [num_pll-1:0] irq_en, next_irq_en;
  logic [num_pll-1:0] irq_stat, next_irq_stat;
  logic [num_pll-1:0] lol_clr;
  logic [num_pll-1:0] irq_clr;

  // Bus state
  logic [addr_w-1:0] aw_adr, next_aw_adr;
  logic aw_full, next_aw_full;
  logic [31:0] w_dat, next_w_dat;
  logic [3:0] w_stb, next_w_stb;
  logic w_full, next_w_full;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic do_wr;

  // Pin path state
  logic [pins-1:0] pin_sync;
  logic [pins-1:0] pin_in_reg, next_pin_in_reg;
  logic [pins-1:0] next_pin_o, next_pin_oe;
  logic [num_pll-1:0] sticky, changed;
  logic next_irq;
  logic alert_any;
  logic active;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] stb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (stb[b]) begin
        r[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_cfg(input logic [addr_w-1:0] a);
    return (a >= adr_pin_cfg0) &&
           (a < adr_pin_cfg0 + addr_w'(pins * 4)) && (a[1:0] == 2'b00);
  endfunction

  function automatic int unsigned cfg_idx(input logic [addr_w-1:0] a);
    return int'((a - adr_pin_cfg0) >> 2);
  endfunction

  function automatic logic is_mapped(input logic [addr_w-1:0] a);
    return (a == adr_pin_in) || (a == adr_pin_out) ||
           (a == adr_lol_sticky) || (a == adr_lol_clear) ||
           (a == adr_alert_en) || (a == adr_irq_status) ||
           (a == adr_irq_clear) || (a == adr_irq_enable) ||
           (a == adr_ready) || is_cfg(a);
  endfunction

  sync3 #(.width(pins)) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in(pin_i),
    .sync_out(pin_sync)
  );

  lol_sticky #(.width(num_pll)) u_sticky (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .locked(pll_locked),
    .clear(lol_clr),
    .sticky(sticky),
    .changed(changed)
  );

  // AXI4-Lite write and read channels
  always_comb begin
    next_aw_adr = aw_adr;
    next_aw_full = aw_full;
    next_w_dat = w_dat;
    next_w_stb = w_stb;
    next_w_full = w_full;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_adr = s_axi_awaddr;
      next_aw_full = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_dat = s_axi_wdata;
      next_w_stb = s_axi_wstrb;
      next_w_full = 1'b1;
    end
    do_wr = aw_full && w_full && !s_axi_bvalid;
    if (do_wr) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = is_mapped(aw_adr) ? resp_okay : resp_slverr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = is_mapped(s_axi_araddr) ? resp_okay : resp_slverr;
      next_rdata = '0;
      case (s_axi_araddr)
        adr_pin_in: next_rdata[pins-1:0] = pin_in_reg;
        adr_pin_out: next_rdata[pins-1:0] = out_val;
        adr_lol_sticky: next_rdata[num_pll-1:0] = sticky;
        adr_alert_en: next_rdata[num_pll-1:0] = alert_en;
        adr_irq_status: next_rdata[num_pll-1:0] = irq_stat;
        adr_irq_enable: next_rdata[num_pll-1:0] = irq_en;
        adr_ready: next_rdata[0] = reset_done;
        default: begin
          if (is_cfg(s_axi_araddr)) begin
            next_rdata = cfg[cfg_idx(s_axi_araddr)];
          end
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Register writes
  always_comb begin
    next_out_val = out_val;
    next_alert_en = alert_en;
    next_irq_en = irq_en;
    lol_clr = '0;
    irq_clr = '0;
    for (int i = 0; i < pins; i++) begin
      next_cfg[i] = cfg[i];
    end
    if (do_wr) begin
      case (aw_adr)
        adr_pin_out: begin
          next_out_val = pins'(merge(32'(out_val), w_dat,
                                     w_stb));
        end
        adr_lol_clear: lol_clr = w_dat[num_pll-1:0];
        adr_alert_en: next_alert_en = w_dat[num_pll-1:0];
        adr_irq_clear: irq_clr = w_dat[num_pll-1:0];
        adr_irq_enable: next_irq_en = w_dat[num_pll-1:0];
        default: begin
          if (is_cfg(aw_adr)) begin
            next_cfg[cfg_idx(aw_adr)] = merge(cfg[cfg_idx(aw_adr)],
                                             w_dat, w_stb);
          end
        end
      endcase
    end
    // Change events set, set beats clear
    next_irq_stat = (irq_stat & ~irq_clr) | changed;
    next_irq = |(next_irq_stat & next_irq_en);
  end

  // Pin function mux
  always_comb begin
    active = reset_done;
    alert_any = |(sticky & alert_en);
    next_pin_in_reg = pin_sync;
    next_pin_o = '0;
    next_pin_oe = '0;
    for (int i = 0; i < pins; i++) begin
      logic [sel_w-1:0] sel;
      logic inv;
      logic lvl;
      sel = cfg[i][cfg_sel_lsb +: sel_w];
      inv = cfg[i][cfg_inv_bit];
      lvl = 1'b0;
      // Same config gives same output, per pin
      case (pin_mode_e'(cfg[i][cfg_mode_lsb +: 3]))
        mode_output: lvl = out_val[i];
        mode_los: lvl = los_alarm[sel] ^ inv;
        mode_lol_live: lvl = ~pll_locked[sel] ^ inv;
        mode_lol_sticky: lvl = sticky[sel] ^ inv;
        mode_alert: lvl = alert_any ^ inv;
        default: lvl = 1'b0;
      endcase
      if (active && (cfg[i][cfg_mode_lsb +: 3] != 3'(mode_input))) begin
        next_pin_o[i] = lvl;
        next_pin_oe[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int i = 0; i < pins; i++) begin
        cfg[i] <= cfg_reset;
      end
      out_val <= '0;
      alert_en <= '0;
      irq_en <= '0;
      irq_stat <= '0;
      aw_adr <= '0;
      aw_full <= 1'b0;
      w_dat <= '0;
      w_stb <= '0;
      w_full <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= resp_okay;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      pin_in_reg <= '0;
      pin_o <= '0;
      pin_oe <= '0;
      irq <= 1'b0;
    end else begin
      for (int i = 0; i < pins; i++) begin
        cfg[i] <= next_cfg[i];
      end
      out_val <= next_out_val;
      alert_en <= next_alert_en;
      irq_en <= next_irq_en;
      irq_stat <= next_irq_stat;
      aw_adr <= next_aw_adr;
      aw_full <= next_aw_full;
      w_dat <= next_w_dat;
      w_stb <= next_w_stb;
      w_full <= next_w_full;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      s_axi_awready <= !next_aw_full && !next_bvalid &&
                       !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !next_w_full && !next_bvalid &&
                      !(s_axi_wvalid && s_axi_wready);
      s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
      pin_in_reg <= next_pin_in_reg;
      pin_o <= next_pin_o;
      pin_oe <= next_pin_oe;
      irq <= next_irq;
    end
  end
endmodule // gpio_top

// ### gpio_top_props.sv
// Checker for the multi-function pin block ports.
// Assumes one sys_clk domain and rstn active low.
`timescale 1ns/1ps
module gpio_top_props
  import gpio_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic reset_done,
  input wire logic [gpio_pkg::num_pins-1:0] pin_oe,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_wait_done;
    !reset_done |=> pin_oe == 16'h0;
  endproperty
  a_wait_done: assert property (p_wait_done)
    else $error("pin driven before reset done");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");
  property p_w_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_w_answer: assert property (p_w_answer)
    else $error("write response late");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read response late");
  property p_w_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_refuse: assert property (p_w_refuse)
    else $error("write taken while response pending");
  property p_r_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_refuse: assert property (p_r_refuse)
    else $error("read taken while response pending");
  property p_err_zero;
    s_axi_rvalid && s_axi_rresp == resp_slverr |-> s_axi_rdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("error read with data");
endmodule // gpio_top_props

bind gpio_top gpio_top_props i_props (.*);

// ### lol_sticky.sv
// Per-PLL sticky change flags with set-over-clear.
// Assumes lock inputs already in the sys_clk domain.
`timescale 1ns/1ps
module lol_sticky #(
  parameter int unsigned width = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [width-1:0] locked,
  input wire logic [width-1:0] clear,
  output logic [width-1:0] sticky,
  output logic [width-1:0] changed
);
  logic [width-1:0] locked_d;
  logic [width-1:0] next_sticky;

  always_comb begin
    changed = locked ^ locked_d;
    // Set wins over clear; no self-clear
    next_sticky = (sticky & ~clear) | changed;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      locked_d <= '0;
      sticky <= '0;
    end else begin
      locked_d <= locked;
      sticky <= next_sticky;
    end
  end
endmodule // lol_sticky

// ### multifunction_status_pins_tb.sv
// Self-checking bench for the multi-function pin block.
// Assumes the gpio_pkg register map and a board model on the pins.
`timescale 1ns/1ps
module multifunction_status_pins_tb;
  import gpio_pkg::*;
  logic sys_clk = 0, rstn = 0, reset_done = 0, irq;
  logic [7:0] los_alarm = 0, pll_locked = 0, stk = 0, ist = 0, aen, ien, m;
  logic [15:0] board_lvl = 0, pin_i, pin_o, pin_oe, pout;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [2:0] md [16] = '{default: 3'h0};
  logic [2:0] sl [16] = '{default: 3'h0};
  logic iv [16] = '{default: 1'b0};
  int num_errors = 0, n_checks = 0;

  always #2 sys_clk = ~sys_clk;
  gpio_top i_dut (.*);
  board_pins i_board (.*);

  task stop_test;
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk_reg(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t reg got %h exp %h", $time, g, e);
    end
  endtask
  task chk_pin(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t pins got %h exp %h", $time, g, e);
    end
  endtask
  task tmo(input int n);
    if (n >= 64) begin
      num_errors++;
      $display("MISMATCH %0t bus timeout", $time);
      stop_test;
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready === 1) s_axi_awvalid <= 0;
      if (s_axi_wready === 1) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1 && n < 64);
    s_axi_bready <= 0;
    rr = s_axi_bresp;
    tmo(n);
  endtask
  task rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready === 1) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1 && n < 64);
    s_axi_rready <= 0;
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    tmo(n);
  endtask
  task step(input logic [7:0] l, input logic [7:0] p);
    stk = stk | (pll_locked ^ p);
    ist = ist | (pll_locked ^ p);
    los_alarm <= l;
    pll_locked <= p;
  endtask
  function logic [31:0] cfg(input int n);
    return {23'h0, iv[n], 1'b0, sl[n], 1'b0, md[n]};
  endfunction
  function logic [15:0] exp_oe();
    logic [15:0] e;
    for (int n = 0; n < 16; n++) e[n] = md[n] != mode_input;
    return e;
  endfunction
  function logic [15:0] exp_o();
    logic [15:0] e;
    e = 16'h0;
    for (int n = 0; n < 16; n++) begin
      case (md[n])
        mode_output: e[n] = pout[n];
        mode_los: e[n] = los_alarm[sl[n]] ^ iv[n];
        mode_lol_live: e[n] = !pll_locked[sl[n]] ^ iv[n];
        mode_lol_sticky: e[n] = stk[sl[n]] ^ iv[n];
        mode_alert: e[n] = (|(stk & aen)) ^ iv[n];
        default: e[n] = 1'b0;
      endcase
    end
    return e;
  endfunction

  initial begin
    void'($urandom(32'h9fa802a9));
    cyc(4);
    rstn <= 1;
    cyc(2);
    rdr(adr_pin_cfg0 + 8'h3c);
    chk_reg(rd, cfg_reset);
    rdr(8'h3c);
    chk_reg({30'h0, rr}, {30'h0, resp_slverr});
    md[0] = mode_output;
    pout = 16'h0001;
    wr(adr_pin_out, {16'h0, pout});
    wr(adr_pin_cfg0, cfg(0));
    chk_reg({30'h0, rr}, {30'h0, resp_okay});
    wr(8'h3c, 32'h0);
    chk_reg({30'h0, rr}, {30'h0, resp_slverr});
    cyc(3);
    chk_pin(pin_oe, 16'h0);
    reset_done <= 1;
    cyc(3);
    chk_pin(pin_o, exp_o());
    rdr(adr_ready);
    chk_reg(rd, 32'h1);
    for (int n = 2; n < 16; n++) begin
      md[n] = (n < 6) ? 3'(n) : 3'(2 + $urandom_range(3));
      sl[n] = 3'($urandom_range(7));
      iv[n] = 1'($urandom);
      if (n == 15) begin
        md[15] = md[14];
        sl[15] = sl[14];
        iv[15] = iv[14];
      end
      wr(adr_pin_cfg0 + 8'(4 * n), cfg(n));
    end
    aen = 8'($urandom);
    wr(adr_alert_en, {24'h0, aen});
    ien = 8'($urandom);
    wr(adr_irq_enable, {24'h0, ien});
    for (int i = 0; i < 16; i++) begin
      board_lvl <= 16'($urandom);
      pout = 16'($urandom);
      wr(adr_pin_out, {16'h0, pout});
      step(8'($urandom), (i % 4 == 3) ? pll_locked : 8'($urandom));
      cyc(4);
      chk_pin(pin_o, exp_o());
      chk_pin(pin_oe, exp_oe());
      chk_pin({15'h0, irq}, {15'h0, |(ist & ien)});
      rdr(adr_lol_sticky);
      chk_reg(rd, {24'h0, stk});
      rdr(adr_pin_in);
      chk_pin(rd[15:0] & 16'h0002, board_lvl & 16'h0002);
      if (i % 3 == 2) begin
        m = 8'($urandom);
        wr(adr_lol_clear, {24'h0, m});
        stk = stk & ~m;
        cyc(4);
        chk_pin(pin_o, exp_o());
      end
    end
    s_axi_wstrb <= 4'h1;
    wr(adr_pin_out, 32'hffff_ffff);
    s_axi_wstrb <= 4'hf;
    pout[7:0] = 8'hff;
    rdr(adr_pin_out);
    chk_reg(rd, {16'h0, pout});
    md[13] = 3'h6;
    wr(adr_pin_cfg0 + 8'h34, cfg(13));
    cyc(2);
    chk_pin(pin_oe, exp_oe());
    chk_pin(pin_o, exp_o());
    ien = 8'h0;
    wr(adr_irq_enable, 32'h0);
    step(los_alarm, ~pll_locked);
    cyc(4);
    chk_pin({15'h0, irq}, 16'h0);
    rdr(adr_irq_status);
    chk_reg(rd, {24'h0, ist});
    ien = 8'hff;
    wr(adr_irq_enable, 32'hff);
    cyc(3);
    chk_pin({15'h0, irq}, 16'h1);
    wr(adr_irq_clear, 32'hff);
    cyc(3);
    chk_pin({15'h0, irq}, 16'h0);
    stop_test;
  end
endmodule // multifunction_status_pins_tb

// ### sync3.sv
// Three-stage synchroniser with agreement check on a bus of levels.
// Assumes inputs arrive from outside the sys_clk domain.
`timescale 1ns/1ps
module sync3 #(
  parameter int unsigned width = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] s1, s2, s3;
  logic [width-1:0] next_sync_out;

  always_comb begin
    next_sync_out = sync_out;
    for (int i = 0; i < width; i++) begin
      // Change counts once stage two and three agree
      if (s2[i] == s3[i]) begin
        next_sync_out[i] = s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      sync_out <= '0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      sync_out <= next_sync_out;
    end
  end
endmodule // sync3
